// File: ethreg_top.sv
// APB register block, flow control, pin routing and reference clock of the Ethernet controller
`timescale 1ns/1ps
`default_nettype none
module ethreg_top import ethreg_pkg::*; (
  input  wire logic        pclk,                 // APB clock, 100 MHz
  input  wire logic        presetn,              // Async reset, active low
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        media_iface_select,   // 0 selects RMII
  input  wire logic        pin_group_select,     // 1 default pins, 0 alternate
  input  wire logic [47:0] factory_station_addr, // Factory programmed address
  input  wire logic        core_tx_en,           // MAC core RMII side
  input  wire logic [1:0]  core_txd,
  input  wire logic        core_mdc,
  input  wire logic        core_mdio_o,
  input  wire logic        core_mdio_oe,
  output logic             core_mdio_i,
  output logic             core_crs_dv,
  output logic      [1:0]  core_rxd,
  output logic             core_rx_err,
  output logic             def_tx_en,            // Default pin group
  output logic      [1:0]  def_txd,
  output logic             def_ref_clk,
  output logic             def_mdc,
  output logic             def_mdio_o,
  output logic             def_mdio_oe,
  input  wire logic        def_mdio_i,
  input  wire logic        def_crs_dv,
  input  wire logic [1:0]  def_rxd,
  input  wire logic        def_rx_err,
  output logic             alt_tx_en,            // Alternate pin group
  output logic      [1:0]  alt_txd,
  output logic             alt_ref_clk,
  output logic             alt_mdc,
  output logic             alt_mdio_o,
  output logic             alt_mdio_oe,
  input  wire logic        alt_mdio_i,
  input  wire logic        alt_crs_dv,
  input  wire logic [1:0]  alt_rxd,
  input  wire logic        alt_rx_err,
  input  wire logic        tx_done_all,          // Core finished descriptor list
  input  wire logic        rx_buf_inc,           // Core filled one receive buffer
  input  wire logic [6:0]  cnt_inc,              // Statistics events
  input  wire logic [31:0] irq_set,              // Interrupt events, flag positions
  input  wire logic        tx_busy,
  input  wire logic        rx_busy,
  output logic             module_on,
  output logic             rx_enable,
  output logic             tx_run,
  output logic             speed_100,
  output logic             full_duplex,
  output logic      [6:0]  rx_buffer_size,
  output logic      [31:0] tx_desc_start,
  output logic      [31:0] rx_desc_start,
  output logic      [15:0] filter_config,
  output logic      [63:0] hash_table,
  output logic      [63:0] pattern_mask,
  output logic      [15:0] pattern_checksum,
  output logic      [15:0] pattern_offset,
  output logic      [47:0] station_addr,
  output logic             pause_send,
  output logic      [15:0] pause_value,
  output logic             irq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NREG-1:0][31:0] regs;     // Register storage
    logic [7:0]            received_buffer_count;   // Received buffer count
    logic [31:0]           prdata;   // Read data, caught in setup
    logic                  refclk;   // Reference clock divider
    logic [5:0]            txdiv;    // Transmit clock prescaler
    logic [21:0]           ivl;      // Pause repeat interval count
    logic                  flow_on;  // Pause currently asserted
    logic                  auto_on;  // Watermark flow control active
    logic                  psend;    // Pause frame request pulse
    logic [15:0]           pval;     // Pause frame timer value
    logic                  sa_done;  // Factory address loaded
  } er_state_t;

  er_state_t s;       // Current state
  er_state_t next_s;  // Next state

  // Address decode helpers
  logic      hit;
  logic [5:0] idx;
  er_alias_t alias_k;
  logic      acc_ok;

  always_comb begin
    hit = 1'b0;
    idx = '0;
    for (int i = 0; i < NREG; i++) begin
      if (paddr[15:4] == REG_OFS[i][15:4]) begin
        hit = 1'b1;
        idx = 6'(i);
      end
    end
  end
  assign alias_k = er_alias_t'(paddr[3:2]);
  // Status has no alias decode, so alias hits there are errors
  assign acc_ok  = hit && !(idx == 6'(IDX_STAT) && alias_k != ER_ALIAS_NONE);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        wr;
    logic [31:0] cur;
    logic [31:0] val;
    logic        dec;
    logic        tick;
    logic        want;
    logic [7:0]  fwm;
    logic [7:0]  ewm;
    logic [15:0] pause_timer_value;
    wr   = 1'b0;
    cur  = '0;
    val  = '0;
    dec  = 1'b0;
    tick = 1'b0;
    want = 1'b0;
    fwm  = '0;
    ewm  = '0;
    pause_timer_value  = '0;
    next_s       = s;
    next_s.psend = 1'b0;
    next_s.refclk = ~s.refclk;  // 50 MHz out of 100 MHz
    wr = psel && penable && pwrite && acc_ok && idx != 6'(IDX_STAT);
    // Software write through base or alias address
    if (wr) begin
      cur = s.regs[idx];
      unique case (alias_k)
        ER_ALIAS_NONE: val = pwdata;
        ER_ALIAS_CLR:  val = cur & ~pwdata;
        ER_ALIAS_SET:  val = cur | pwdata;
        ER_ALIAS_INV:  val = cur ^ pwdata;
      endcase
      // Only implemented bits change
      next_s.regs[idx] = (cur & ~REG_MASK[idx]) | (val & REG_MASK[idx]);
      // Decrement bit is never stored, so it always reads zero
      dec = (idx == 6'(IDX_CTRL1)) && val[B_BUFFER_COUNT_DECREMENT];
    end
    // Hardware clears transmit request unless software sets it now
    if (tx_done_all && !(wr && idx == 6'(IDX_CTRL1) && val[B_TX_REQUEST])) begin
      next_s.regs[IDX_CTRL1][B_TX_REQUEST] = 1'b0;
    end
    // Simultaneous increment and decrement cancel
    if (rx_buf_inc && !dec) begin
      next_s.received_buffer_count = s.received_buffer_count + 8'h01;
    end else if (dec && !rx_buf_inc) begin
      next_s.received_buffer_count = s.received_buffer_count - 8'h01;
    end
    // Events set flags after the write, so a set beats a clear
    next_s.regs[IDX_IRQ] = next_s.regs[IDX_IRQ] | (irq_set & REG_MASK[IDX_IRQ]);
    // Statistics counters wrap at 16 bits
    for (int i = 0; i < NCNT; i++) begin
      next_s.regs[IDX_CNT0+i][15:0] = next_s.regs[IDX_CNT0+i][15:0] + {15'h0000, cnt_inc[i]};
    end
    // Factory address taken on the first clock after reset release
    if (!s.sa_done) begin
      next_s.sa_done = 1'b1;
      for (int i = 0; i < NSA; i++) begin
        next_s.regs[IDX_SA0+i] = {16'h0000, factory_station_addr[47-16*i -: 16]};
      end
    end
    // Read data caught in the setup phase
    if (psel && !penable) begin
      if (!acc_ok) begin
        next_s.prdata = '0;
      end else if (idx == 6'(IDX_STAT)) begin
        next_s.prdata = '0;
        next_s.prdata[RECEIVED_BUFFER_COUNT_LSB +: 8] = s.received_buffer_count;
        next_s.prdata[B_BUSY]          = tx_busy | rx_busy | s.regs[IDX_CTRL1][B_TX_REQUEST];
        next_s.prdata[B_TXBUSY]        = tx_busy;
        next_s.prdata[B_RXBUSY]        = rx_busy;
      end else begin
        next_s.prdata = s.regs[idx] & REG_MASK[idx];
      end
    end
    // Transmit clock tick: 25 MHz at 100 Mbps, 2.5 MHz at 10 Mbps
    if (s.regs[IDX_SUPP][B_SPEED] ? (s.txdiv >= 6'(TX_DIV_100 - 1)) : (s.txdiv >= 6'(TX_DIV_10 - 1))) begin
      next_s.txdiv = '0;
      tick = 1'b1;
    end else begin
      next_s.txdiv = s.txdiv + 6'h01;
    end
    // Watermarks turn automatic flow control on and off
    fwm = s.regs[IDX_RXWM][FWM_LSB +: 8];
    ewm = s.regs[IDX_RXWM][EWM_LSB +: 8];
    if (!s.regs[IDX_CTRL1][B_AUTO_PAUSE_CTRL]) begin
      next_s.auto_on = 1'b0;
    end else if (s.received_buffer_count >= fwm) begin
      next_s.auto_on = 1'b1;
    end else if (s.received_buffer_count <= ewm) begin
      next_s.auto_on = 1'b0;
    end
    // Pause frame requests
    pause_timer_value  = s.regs[IDX_CTRL1][PTV_LSB +: 16];
    want = s.regs[IDX_CTRL1][B_MANUAL_PAUSE_CTRL] | s.auto_on;
    if (want != s.flow_on) begin
      // Start or stop: one pause frame, zero value on stop
      next_s.flow_on = want;
      next_s.psend   = 1'b1;
      next_s.pval    = want ? pause_timer_value : 16'h0000;
      next_s.ivl     = '0;
    end else if (s.flow_on && tick) begin
      // Repeat after 128 * value / 2 transmit clocks
      if (s.ivl >= (22'(pause_timer_value) * 22'(PAUSE_PER_PTV)) - 22'h000001) begin
        next_s.psend = 1'b1;
        next_s.pval  = pause_timer_value;
        next_s.ivl   = '0;
      end else begin
        next_s.ivl = s.ivl + 22'h000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      for (int i = 0; i < NREG; i++) begin
        s.regs[i] <= REG_RST[i];
      end
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer and control outputs
  // ----------------------------------------------------------------
  // Zero wait state; errors only on unmapped or status alias addresses
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !acc_ok;
  assign prdata  = s.prdata;

  assign module_on        = s.regs[IDX_CTRL1][B_ON];
  assign rx_enable        = s.regs[IDX_CTRL1][B_RXEN];
  assign tx_run           = s.regs[IDX_CTRL1][B_TX_REQUEST];
  assign speed_100        = s.regs[IDX_SUPP][B_SPEED];
  assign full_duplex      = s.regs[IDX_CFG2][B_FULLDPLX];
  assign rx_buffer_size   = s.regs[IDX_CTRL2][RX_BUFFER_SIZE_LSB +: 7]; // 16-byte units
  assign tx_desc_start    = s.regs[IDX_TXST];
  assign rx_desc_start    = s.regs[IDX_RXST];
  assign filter_config    = s.regs[IDX_RXFC][15:0];
  assign hash_table       = {s.regs[IDX_HT0+1], s.regs[IDX_HT0]};
  assign pattern_mask     = {s.regs[IDX_PMM0+1], s.regs[IDX_PMM0]};
  assign pattern_checksum = s.regs[IDX_PMCS][15:0];
  assign pattern_offset   = s.regs[IDX_PMO][15:0];
  assign station_addr     = {s.regs[IDX_SA0][15:0], s.regs[IDX_SA0+1][15:0], s.regs[IDX_SA0+2][15:0]};
  assign pause_send       = s.psend;
  assign pause_value      = s.pval;
  assign irq              = |(s.regs[IDX_IRQ] & s.regs[IDX_IEN]);

  // ----------------------------------------------------------------
  // Pin group routing; unselected group is parked low
  // ----------------------------------------------------------------
  logic use_def;  // Default group active
  logic use_alt;  // Alternate group active
  assign use_def = (media_iface_select == MEDIA_RMII) && (pin_group_select == PIN_DEFAULT);
  assign use_alt = (media_iface_select == MEDIA_RMII) && (pin_group_select != PIN_DEFAULT);

  assign def_tx_en   = use_def & core_tx_en;
  assign def_txd     = use_def ? core_txd : 2'b00;
  assign def_ref_clk = use_def & s.refclk;
  assign def_mdc     = use_def & core_mdc;
  assign def_mdio_o  = use_def & core_mdio_o;
  assign def_mdio_oe = use_def & core_mdio_oe;
  assign alt_tx_en   = use_alt & core_tx_en;
  assign alt_txd     = use_alt ? core_txd : 2'b00;
  assign alt_ref_clk = use_alt & s.refclk;
  assign alt_mdc     = use_alt & core_mdc;
  assign alt_mdio_o  = use_alt & core_mdio_o;
  assign alt_mdio_oe = use_alt & core_mdio_oe;
  assign core_mdio_i = use_def ? def_mdio_i : (use_alt & alt_mdio_i);
  assign core_crs_dv = use_def ? def_crs_dv : (use_alt & alt_crs_dv);
  assign core_rxd    = use_def ? def_rxd : (use_alt ? alt_rxd : 2'b00);
  assign core_rx_err = use_def ? def_rx_err : (use_alt & alt_rx_err);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence set_alias_ctrl2_s;
    psel && penable && pwrite && paddr == (REG_OFS[IDX_CTRL2] | 16'h0008) && pwdata[RX_BUFFER_SIZE_LSB];
  endsequence
  sequence manual_stop_s;
    $fell(s.regs[IDX_CTRL1][B_MANUAL_PAUSE_CTRL]) && !s.auto_on;
  endsequence

  alias_set_a: assert property (set_alias_ctrl2_s |=> rx_buffer_size[0])
    else $error("set alias did not set the bit");
  alias_keep_a: assert property (set_alias_ctrl2_s ##1 1'b1 |-> $stable(rx_buffer_size[6:1])
    || $past(pwdata[RX_BUFFER_SIZE_LSB+1 +: 6]) != 6'h00)
    else $error("set alias changed bits not written");
  status_alias_a: assert property (psel && penable && paddr[15:4] == REG_OFS[IDX_STAT][15:4]
    && paddr[3:2] != 2'b00 |-> pslverr)
    else $error("status alias was decoded");
  pin_default_a: assert property (use_def |-> def_txd == core_txd && alt_tx_en == 1'b0 && !alt_mdio_oe)
    else $error("default group not routed");
  pin_alt_a: assert property (use_alt |-> alt_tx_en == core_tx_en && def_tx_en == 1'b0)
    else $error("alternate group not routed");
  buf_both_a: assert property (psel && penable && pwrite && paddr == REG_OFS[IDX_CTRL1]
    && pwdata[B_BUFFER_COUNT_DECREMENT] && rx_buf_inc |=> s.received_buffer_count == $past(s.received_buffer_count))
    else $error("count moved on cancelling events");
  tx_request_done_a: assert property (tx_done_all && !(psel && penable && pwrite) |=> !tx_run)
    else $error("transmit request not cleared");
  pause_stop_a: assert property (manual_stop_s |-> ##1 (pause_send && pause_value == 16'h0000))
    else $error("no zero pause on stop");
  ref_clk_a: assert property ($past(presetn) |-> s.refclk != $past(s.refclk))
    else $error("reference clock divider stalled");
  irq_flag_a: assert property (irq_set[0] ##1 s.regs[IDX_IEN][0] |-> irq)
    else $error("enabled flag gave no interrupt");
endmodule : ethreg_top
`default_nettype wire

// File: ethreg_pkg.sv
// Constants, register map and field layout of the Ethernet controller register block
//
// Contract
// - Non-status registers get clear/set/invert aliases at +4/+8/+C
// - Status register has no alias addresses
// - RMII with pin selector 1 uses default pins
// - RMII with pin selector 0 uses alternate pins
// - RMII data pins plus management clock and data
// - Runs 10 or 100 Mbps, full or half duplex
// - DMA walks transmit and receive descriptor lists
// - Receive filter configurable by several criteria
// - Manual and watermark driven automatic flow control
// - Payload checksum computed in hardware for software
// - Seven 16-bit statistics counters
// - Device drives the RMII reference clock out
// - Unimplemented bits read zero, writes ignored
// - Station address resets from factory value
// - Transmit request cleared by hardware when done
// - Decrement bit lowers buffer count, reads zero
// - Manual pause frames repeat; clearing sends zero pause
// - Receive buffer size in 16-byte units
package ethreg_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          NREG     = 33;
  localparam logic [15:0] REG_OFS [NREG] = '{
    16'h3000, 16'h3010, 16'h3020, 16'h3030, 16'h3040, 16'h3050, 16'h3060, 16'h3070, 16'h3080,
    16'h3090, 16'h30a0, 16'h30b0, 16'h30c0, 16'h30d0, 16'h30e0, 16'h3100, 16'h3110, 16'h3120,
    16'h3130, 16'h3140, 16'h3150, 16'h3160, 16'h3200, 16'h3210, 16'h3220, 16'h3230, 16'h3240,
    16'h3250, 16'h3260, 16'h3270, 16'h3300, 16'h3310, 16'h3320};
  // Implemented (storable) bits; everything else reads zero
  localparam logic [31:0] REG_MASK [NREG] = '{
    32'hffffa390, 32'h000007f0, 32'hfffffffc, 32'hfffffffc, 32'hffffffff, 32'hffffffff,
    32'hffffffff, 32'hffffffff, 32'h0000ffff, 32'h0000ffff, 32'h0000dfff, 32'h00ff00ff,
    32'h000063ef, 32'h000063ef, 32'h00000000, 32'h0000ffff, 32'h0000ffff, 32'h0000ffff,
    32'h0000ffff, 32'h0000ffff, 32'h0000ffff, 32'h0000ffff, 32'h0000cf1f, 32'h000073ff,
    32'h0000007f, 32'h00007f7f, 32'h00003f0f, 32'h0000ffff, 32'h00001900, 32'h00000007,
    32'h0000ffff, 32'h0000ffff, 32'h0000ffff};
  localparam logic [31:0] REG_RST [NREG] = '{
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000800d, 32'h000040b2,
    32'h00000012, 32'h00000c12, 32'h0000370f, 32'h000005ee, 32'h00001000, 32'h0, 32'h0, 32'h0,
    32'h0};
  // Register indices
  localparam int IDX_CTRL1 = 0;
  localparam int IDX_CTRL2 = 1;
  localparam int IDX_TXST  = 2;
  localparam int IDX_RXST  = 3;
  localparam int IDX_HT0   = 4;
  localparam int IDX_PMM0  = 6;
  localparam int IDX_PMCS  = 8;
  localparam int IDX_PMO   = 9;
  localparam int IDX_RXFC  = 10;
  localparam int IDX_RXWM  = 11;
  localparam int IDX_IEN   = 12;
  localparam int IDX_IRQ   = 13;
  localparam int IDX_STAT  = 14;
  localparam int IDX_CNT0  = 15;
  localparam int NCNT      = 7;
  localparam int IDX_CFG2  = 23;
  localparam int IDX_SUPP  = 28;
  localparam int IDX_SA0   = 30;
  localparam int NSA       = 3;
  // ----------------------------------------------------------------
  // Alias kinds (address bits 3:2) and field positions
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ER_ALIAS_NONE, ER_ALIAS_CLR, ER_ALIAS_SET, ER_ALIAS_INV} er_alias_t;
  localparam int B_BUFFER_COUNT_DECREMENT   = 0;
  localparam int B_MANUAL_PAUSE_CTRL     = 4;
  localparam int B_AUTO_PAUSE_CTRL    = 7;
  localparam int B_RXEN      = 8;
  localparam int B_TX_REQUEST     = 9;
  localparam int B_ON        = 15;
  localparam int PTV_LSB     = 16;
  localparam int RX_BUFFER_SIZE_LSB = 4;
  localparam int EWM_LSB     = 0;
  localparam int FWM_LSB     = 16;
  localparam int B_FULLDPLX  = 0;
  localparam int B_SPEED     = 8;
  localparam int RECEIVED_BUFFER_COUNT_LSB  = 16;
  localparam int B_BUSY      = 7;
  localparam int B_TXBUSY    = 6;
  localparam int B_RXBUSY    = 5;
  localparam logic MEDIA_RMII  = 1'b0;
  localparam logic PIN_DEFAULT = 1'b1;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int PCLK_HZ      = 100_000_000;
  localparam int TXCLK100_HZ  = 25_000_000;
  localparam int TXCLK10_HZ   = 2_500_000;
  localparam int TX_DIV_100   = PCLK_HZ / TXCLK100_HZ;
  localparam int TX_DIV_10    = PCLK_HZ / TXCLK10_HZ;
  localparam int PAUSE_MULT   = 128;
  localparam int PAUSE_DIV    = 2;
  localparam int PAUSE_PER_PTV = PAUSE_MULT / PAUSE_DIV;
endpackage : ethreg_pkg

// File: ethreg_phy_model.sv
// Behavioural RMII PHY model standing on one pin group of the controller
`timescale 1ns/1ps
`default_nettype none
module ethreg_phy_model (
  input  wire logic       ref_clk, // Reference clock from the device
  input  wire logic       tx_en,   // Transmit enable pin
  input  wire logic [1:0] txd,     // Transmit dibit
  input  wire logic       mdio_o,  // Device level on the management line
  input  wire logic       mdio_oe, // High while the device drives it
  output logic            crs_dv,  // Carrier sense and data valid
  output logic      [1:0] rxd,     // Receive dibit
  output logic            rx_err,  // Receive error
  output logic            mdio_i   // Resolved management line
);
  // ------------------------------------------------------------
  // Loopback on the reference clock, which stops while unrouted
  // ------------------------------------------------------------
  initial {crs_dv, rxd, rx_err} = 4'h2;
  // Idle dibits toggle so a stale copy never passes for data
  always @(posedge ref_clk) begin
    crs_dv <= tx_en;
    rxd    <= tx_en ? txd : ~rxd;
    rx_err <= 1'b0;
  end
  // Pull-up holds the line high when nobody drives it
  assign mdio_i = mdio_oe ? mdio_o : 1'b1;
endmodule : ethreg_phy_model
`default_nettype wire

// File: rmii_ethernet_mac_regs_tb.sv
// Self-checking bench for the Ethernet controller register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module rmii_ethernet_mac_regs_tb import ethreg_pkg::*; ;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam logic [47:0] FACTORY_MAC = 48'h0a1b_2c3d_4e5f; // Arbitrary value
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0, pause_value, pval;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        media = 1'b0, pin_sel = 1'b1, tx_done = 1'b0, buf_inc = 1'b0, err, tx_run;
  logic        core_tx_en = 1'b0, core_mdio_oe = 1'b0, core_mdio_i, core_crs_dv, core_rx_err;
  logic        pready, pslverr, pause_send, def_tx_en, alt_tx_en, def_ref_clk, alt_ref_clk;
  logic        def_mdo, alt_mdo, def_oe, alt_oe, def_mdi, alt_mdi, def_crs, alt_crs, def_err, alt_err;
  logic [1:0]  core_txd = 2'h0, core_rxd, def_txd, alt_txd, def_rxd, alt_rxd;
  logic [6:0]  cnt_inc = 7'h0, rx_buffer_size;
  logic [31:0] irq_set = 32'h0;
  logic        irq;
  int          mismatches = 0, cmp_count = 0, cyc = 0, n, pcount = 0, pgap = 0, plast = 0;
  always #5 pclk = ~pclk;
  ethreg_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .media_iface_select(media), .pin_group_select(pin_sel), .factory_station_addr(FACTORY_MAC),
    .core_tx_en, .core_txd, .core_mdc(1'b0), .core_mdio_o(1'b0), .core_mdio_oe, .core_mdio_i,
    .core_crs_dv, .core_rxd, .core_rx_err, .def_tx_en, .def_txd, .def_ref_clk, .def_mdc(),
    .def_mdio_o(def_mdo), .def_mdio_oe(def_oe), .def_mdio_i(def_mdi), .def_crs_dv(def_crs), .def_rxd,
    .def_rx_err(def_err), .alt_tx_en, .alt_txd, .alt_ref_clk, .alt_mdc(), .alt_mdio_o(alt_mdo),
    .alt_mdio_oe(alt_oe), .alt_mdio_i(alt_mdi), .alt_crs_dv(alt_crs), .alt_rxd, .alt_rx_err(alt_err),
    .tx_done_all(tx_done), .rx_buf_inc(buf_inc), .cnt_inc, .irq_set, .tx_busy(1'b0),
    .rx_busy(1'b0), .module_on(), .rx_enable(), .tx_run, .speed_100(), .full_duplex(), .rx_buffer_size,
    .tx_desc_start(), .rx_desc_start(), .filter_config(), .hash_table(), .pattern_mask(),
    .pattern_checksum(), .pattern_offset(), .station_addr(), .pause_send, .pause_value, .irq);
  ethreg_phy_model phy_def (.ref_clk(def_ref_clk), .tx_en(def_tx_en), .txd(def_txd), .mdio_o(def_mdo),
    .mdio_oe(def_oe), .crs_dv(def_crs), .rxd(def_rxd), .rx_err(def_err), .mdio_i(def_mdi));
  ethreg_phy_model phy_alt (.ref_clk(alt_ref_clk), .tx_en(alt_tx_en), .txd(alt_txd), .mdio_o(alt_mdo),
    .mdio_oe(alt_oe), .crs_dv(alt_crs), .rxd(alt_rxd), .rx_err(alt_err), .mdio_i(alt_mdi));
  // Cycle count, pause pulse log and hang guard
  always @(posedge pclk) begin
    cyc++;
    if (pause_send === 1'b1) begin
      pcount++; pgap = cyc - plast; plast = cyc; pval = pause_value;
    end
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // ------------------------------------------------------------
  // Bus and helper tasks
  // ------------------------------------------------------------
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rchk(input string nm, input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `CHK(nm, exp, rd)
  endtask : rchk
  task automatic wait_pulses(input int k);
    n = 0;
    // Two full repeat periods at 10 Mbps need about 5200 cycles
    while (pcount < k && n < 6000) begin @(posedge pclk); n++; end
    if (pcount < k) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : wait_pulses
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rchk("ctrl_one", 16'h3000, 32'h0);
    rchk("mac_config_one", 16'h3200, 32'h800d);
    rchk("mac_config_two", 16'h3210, 32'h40b2);
    rchk("non_b2b_gap", 16'h3230, 32'h0c12);
    rchk("mac_support", 16'h3260, 32'h1000);
    rchk("station_addr_0", 16'h3300, {16'h0, FACTORY_MAC[47:32]});
    rchk("station_addr_2", 16'h3320, {16'h0, FACTORY_MAC[15:0]});
    $display("test reset values done");
  endtask : t_reset
  task automatic t_alias();
    apb(1'b1, 16'h3010, 32'hffffffff);
    rchk("ctrl_two masked", 16'h3010, 32'h7f0);
    `CHK("buffer size", 7'h7f, rx_buffer_size)
    apb(1'b1, 16'h3014, 32'h410);
    rchk("ctrl_two clear", 16'h3010, 32'h3e0);
    apb(1'b1, 16'h3018, 32'h10);
    rchk("ctrl_two set", 16'h3010, 32'h3f0);
    apb(1'b1, 16'h301c, 32'hc30);
    rchk("ctrl_two invert", 16'h3010, 32'h7c0);
    apb(1'b1, 16'h30e4, 32'h1);
    `CHK("status alias", 1'b1, err)
    apb(1'b0, 16'h30ec, 32'h0);
    `CHK("status invert", 1'b1, err)
    $display("test alias done");
  endtask : t_alias
  task automatic t_pins();
    core_tx_en <= 1'b1; core_txd <= 2'b10;
    repeat (6) @(posedge pclk);
    `CHK("default tx_en", 1'b1, def_tx_en)
    `CHK("alternate tx_en", 1'b0, alt_tx_en)
    `CHK("looped rxd", 2'b10, core_rxd)
    `CHK("carrier", 1'b1, core_crs_dv)
    `CHK("mdio pull-up", 1'b1, core_mdio_i)
    pin_sel <= 1'b0; core_txd <= 2'b01;
    repeat (6) @(posedge pclk);
    `CHK("alternate txd", 2'b01, alt_txd)
    `CHK("default tx_en off", 1'b0, def_tx_en)
    `CHK("alt looped rxd", 2'b01, core_rxd)
    #1 rd[0] = alt_ref_clk;
    @(posedge pclk) #1;
    `CHK("ref clock toggles", ~rd[0], alt_ref_clk)
    @(posedge pclk) media <= 1'b1;
    @(posedge pclk) #1;
    `CHK("no group routed", 2'b00, {def_tx_en, alt_tx_en})
    @(posedge pclk) core_tx_en <= 1'b0;
    media <= 1'b0;
    $display("test pins done");
  endtask : t_pins
  task automatic t_events();
    apb(1'b1, 16'h3008, 32'h200);
    `CHK("tx_run set", 1'b1, tx_run)
    tx_done <= 1'b1;
    @(posedge pclk) tx_done <= 1'b0;
    @(posedge pclk) buf_inc <= 1'b1;
    `CHK("tx_run cleared", 1'b0, tx_run)
    repeat (2) @(posedge pclk);
    buf_inc <= 1'b0;
    rchk("two buffers", 16'h30e0, 32'h0002_0000);
    apb(1'b1, 16'h3008, 32'h1);
    rchk("one buffer", 16'h30e0, 32'h0001_0000);
    rchk("decrement reads zero", 16'h3000, 32'h0);
    cnt_inc <= 7'h41;
    @(posedge pclk) cnt_inc <= 7'h0;
    @(posedge pclk);
    rchk("overflow count", 16'h3100, 32'h1);
    rchk("align count", 16'h3160, 32'h1);
    apb(1'b1, 16'h30c0, 32'h1);
    irq_set <= 32'h1;
    @(posedge pclk) irq_set <= 32'h0;
    @(posedge pclk);
    `CHK("irq raised", 1'b1, irq)
    apb(1'b1, 16'h30c4, 32'h1);
    `CHK("irq masked", 1'b0, irq)
    $display("test events done");
  endtask : t_events
  task automatic t_pause();
    apb(1'b1, 16'h3000, 32'h0001_0010);
    wait_pulses(3);
    `CHK("pause value", 16'h1, pval)
    `CHK("repeat period", 2560, pgap)
    apb(1'b1, 16'h3004, 32'h10);
    wait_pulses(4);
    `CHK("zero pause", 16'h0, pval)
    repeat (300) @(posedge pclk);
    `CHK("pauses stop", 4, pcount)
    $display("test pause done");
  endtask : t_pause
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  // Reset for three cycles, then every scenario in turn
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset();
    t_alias();
    t_pins();
    t_events();
    t_pause();
    tally_and_finish();
  end
endmodule : rmii_ethernet_mac_regs_tb
`default_nettype wire
